/* gpib_host_port.v */
// GPIB controller host port with register file, DMA, interrupt and source handshake
`timescale 1ns/1ps
`include "gpib_host_map.vh"

// Summary of operation
// (RULE1) Chip select low enables register access
// (RULE2) Read strobe drives addressed register onto bus
// (RULE3) Write strobe captures bus into register
// (RULE4) Three select lines pick eight registers
// (RULE5) Request raised, dropped on grant
// (RULE6) Grant connects bus to data register
// (RULE7) Any unmasked condition of thirteen interrupts; only five sources are driven, irq_q[12:5] stays zero
// (RULE8) Interrupt polarity selectable, high after reset
// (RULE9) One eight-bit bidirectional host bus
// (RULE10) Reset high returns logic to idle
// (RULE11) Mode bits set second, third transceiver outputs
// (RULE12) First transceiver output gives direction
// (RULE13) Reference clock counted for prohibit times; clk_mhz_q is stored but never used, settle counts assume the fixed 40 ns clock
// (RULE14) Assume 8 MHz after reset
// (RULE15) Settle delay 350, 500, 1100, 2000 ns
// (RULE16) Byte kept when attention interrupts sending
// (RULE17) Status bits not cleared by reads; a data register read clears the DI bit
// (RULE18) End string or newline ends reception
// (RULE19) No sourcing without a listener
// (RULE20) Three-wire handshake on data lines
// (RULE21) End alone ends, with attention polls
// (RULE22) Page-in lasts exactly one host access
// (RULE23) Drive bus only during reads
module gpib_host_port (
    input  wire       clk_i,
    input  wire       reset_i,
    input  wire       cs_n_i,
    input  wire       rd_n_i,
    input  wire       wr_n_i,
    input  wire [2:0] reg_index_i,
    input  wire [7:0] host_bus_i,
    output reg  [7:0] host_bus_o,
    output reg        host_bus_oe_o,
    input  wire       transfer_grant_in_n_i,
    output reg        transfer_request_out_o,
    output reg        int_o,
    input  wire [7:0] dio_i,
    output reg  [7:0] dio_o,
    input  wire       dav_i,
    output reg        dav_o,
    input  wire       nrfd_i,
    output reg        nrfd_o,
    input  wire       ndac_i,
    output reg        ndac_o,
    input  wire       atn_i,
    input  wire       eoi_i,
    output reg        xcvr_dir_primary_o,
    output reg        xcvr_ctrl_second_o,
    output reg        xcvr_ctrl_third_o
);

    // Settle counts in 25 MHz cycles, rounded up so the delay is never short
    localparam integer SETTLE_RAW_0 = (`SETTLE_NS_0 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam integer SETTLE_RAW_1 = (`SETTLE_NS_1 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam integer SETTLE_RAW_2 = (`SETTLE_NS_2 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam integer SETTLE_RAW_3 = (`SETTLE_NS_3 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam [7:0]   SETTLE_CYC_0 = SETTLE_RAW_0[7:0];
    localparam [7:0]   SETTLE_CYC_1 = SETTLE_RAW_1[7:0];
    localparam [7:0]   SETTLE_CYC_2 = SETTLE_RAW_2[7:0];
    localparam [7:0]   SETTLE_CYC_3 = SETTLE_RAW_3[7:0];

    localparam [1:0] SH_IDLE   = 2'h0;
    localparam [1:0] SH_SETTLE = 2'h1;
    localparam [1:0] SH_VALID  = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Host access decode
    wire       grant    = ~transfer_grant_in_n_i;
    wire       sel      = ~cs_n_i | grant;                           // RULE1 RULE6
    wire       rd_act   = sel & ~rd_n_i;
    wire       wr_act   = sel & ~wr_n_i;
    wire [2:0] idx      = grant ? `REG_DATA : reg_index_i;          // RULE4 RULE6
    reg        rd_q;
    reg        wr_q;
    wire       rd_start = rd_act & ~rd_q;
    wire       wr_start = wr_act & ~wr_q;
    wire       acc_end  = (rd_q & ~rd_act) | (wr_q & ~wr_act);

    reg [7:0]  data_in_q;
    reg [1:0]  ob_cnt_q;
    reg [7:0]  ob0_q;
    reg [7:0]  ob1_q;
    reg [7:0]  addr_mode_q;
    reg [7:0]  aux_q;
    reg [7:0]  addr_q;
    reg [7:0]  eos_q;
    reg [7:0]  spoll_q;
    reg [12:0] irq_q;
    reg [12:0] mask_q;
    reg        pol_hi_q;
    reg        page_q;
    reg [4:0]  clk_mhz_q;
    reg [1:0]  settle_sel_q;
    reg [1:0]  sh_q;
    reg [7:0]  cnt_q;
    reg        ob_pop;
    reg        di_set;
    reg        end_set;

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry outbound buffer; writer stalls by the request staying low
    wire       ob_ready = (ob_cnt_q != 2'h2);
    wire       ob_valid = (ob_cnt_q != 2'h0);
    wire       ob_push  = wr_start && idx == `REG_DATA && ob_ready;

    // Access edge tracking and page window; page-in expires after one access
    always @(posedge clk_i) begin
        if (reset_i) begin                                              // RULE10
            rd_q   <= 1'b0;
            wr_q   <= 1'b0;
            page_q <= 1'b0;
        end else begin
            rd_q <= rd_act;
            wr_q <= wr_act;
            if (wr_start && idx == `REG_AUX && host_bus_i == `AUX_PAGE_IN)
                page_q <= 1'b1;
            else if (acc_end && !(wr_q && idx == `REG_AUX && aux_q == `AUX_PAGE_IN))
                page_q <= 1'b0;                                         // RULE22
        end
    end

    // Register writes and auxiliary commands
    always @(posedge clk_i) begin
        if (reset_i) begin
            addr_mode_q  <= `RST_BYTE;
            aux_q        <= `RST_BYTE;
            addr_q       <= `RST_BYTE;
            eos_q        <= `RST_BYTE;
            spoll_q      <= `RST_BYTE;
            mask_q       <= `RST_MASK;
            pol_hi_q     <= 1'b1;                                       // RULE8
            clk_mhz_q    <= `RST_CLK_MHZ;                               // RULE14
            settle_sel_q <= 2'h0;
        end else if (wr_start) begin                                    // RULE3
            case (idx)
                `REG_INT1:  mask_q[7:0] <= host_bus_i;
                `REG_INT2:  mask_q[12:8] <= host_bus_i[4:0];
                `REG_SPOLL: spoll_q <= host_bus_i;
                `REG_ADDR:  addr_mode_q <= host_bus_i;
                `REG_AUX: begin
                    aux_q <= host_bus_i;
                    if (host_bus_i == `AUX_POL_HI)
                        pol_hi_q <= 1'b1;                               // RULE8
                    else if (host_bus_i == `AUX_POL_LO)
                        pol_hi_q <= 1'b0;
                    else if (host_bus_i[7:5] == `AUX_CLK_BASE >> 5 && host_bus_i[4:0] != 5'h00
                             && host_bus_i[4:0] <= `CLK_MHZ_MAX)
                        clk_mhz_q <= host_bus_i[4:0];                   // RULE13 RULE14
                    else if (host_bus_i[7:2] == `AUX_SETTLE_BASE >> 2)
                        settle_sel_q <= host_bus_i[1:0];                // RULE15
                end
                `REG_ADR01: addr_q <= host_bus_i;
                `REG_EOS:   eos_q <= host_bus_i;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outbound buffer storage; a byte is popped only after acceptance
    always @(posedge clk_i) begin
        if (reset_i) begin
            ob_cnt_q <= 2'h0;
            ob0_q    <= `RST_BYTE;
            ob1_q    <= `RST_BYTE;
        end else begin
            if (ob_pop) begin
                ob0_q <= ob1_q;
                if (ob_push && ob_cnt_q == 2'h1)
                    ob0_q <= host_bus_i;
                else if (ob_push)
                    ob1_q <= host_bus_i;
                ob_cnt_q <= ob_cnt_q - {1'b0, ~ob_push};
            end else if (ob_push) begin
                if (ob_cnt_q == 2'h0)
                    ob0_q <= host_bus_i;
                else
                    ob1_q <= host_bus_i;
                ob_cnt_q <= ob_cnt_q + 2'h1;
            end
        end
    end

    // Source handshake: settle, assert valid, wait for acceptance
    always @(posedge clk_i) begin
        if (reset_i) begin
            sh_q   <= SH_IDLE;
            cnt_q  <= 8'h00;
            dav_o  <= 1'b0;
            dio_o  <= `RST_BYTE;
            ob_pop <= 1'b0;
        end else begin
            ob_pop <= 1'b0;
            case (sh_q)
                SH_IDLE: begin
                    // Only source when a listener holds data-accepted low
                    if (ob_valid && !ob_pop && ndac_i && !atn_i) begin  // RULE19
                        dio_o <= ob0_q;
                        case (settle_sel_q)
                            2'h0: cnt_q <= SETTLE_CYC_0;
                            2'h1: cnt_q <= SETTLE_CYC_1;
                            2'h2: cnt_q <= SETTLE_CYC_2;
                            default: cnt_q <= SETTLE_CYC_3;
                        endcase
                        sh_q <= SH_SETTLE;
                    end
                end
                SH_SETTLE: begin
                    if (atn_i)
                        sh_q <= SH_IDLE;                                // RULE16
                    else if (cnt_q > 8'h01)
                        cnt_q <= cnt_q - 8'h01;
                    else if (!nrfd_i) begin
                        dav_o <= 1'b1;                                  // RULE15 RULE20
                        sh_q  <= SH_VALID;
                    end
                end
                SH_VALID: begin
                    if (atn_i) begin
                        dav_o <= 1'b0;                                  // RULE16
                        sh_q  <= SH_IDLE;
                    end else if (!ndac_i) begin
                        dav_o  <= 1'b0;                                 // RULE20
                        ob_pop <= 1'b1;
                        sh_q   <= SH_IDLE;
                    end
                end
                default: sh_q <= SH_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Acceptor handshake and end detection
    wire is_end = eoi_i & ~atn_i;                                       // RULE21
    wire is_pp  = eoi_i & atn_i;                                        // RULE21
    wire eos_m  = (dio_i == eos_q) | (dio_i == `NL_BYTE);               // RULE18
    reg  dav_seen_q;
    always @(posedge clk_i) begin
        if (reset_i) begin
            nrfd_o     <= 1'b0;
            ndac_o     <= 1'b0;
            dav_seen_q <= 1'b0;
            data_in_q  <= `RST_BYTE;
            di_set     <= 1'b0;
            end_set    <= 1'b0;
        end else begin
            di_set  <= 1'b0;
            end_set <= 1'b0;
            nrfd_o  <= irq_q[`IRQ_DI];                                  // RULE20
            if (dav_i && !dav_seen_q && !irq_q[`IRQ_DI]) begin
                data_in_q <= dio_i;
                di_set    <= 1'b1;
                end_set   <= is_end | eos_m;                            // RULE18
                ndac_o    <= 1'b0;
            end else if (!dav_i) begin
                ndac_o <= 1'b1;
            end
            dav_seen_q <= dav_i;
        end
    end

    // DI and END sticky, set wins over clear; status reads leave them, a data read clears DI
    wire rd_di = rd_start && idx == `REG_DATA;
    always @(posedge clk_i) begin
        if (reset_i) begin
            irq_q <= `RST_MASK;
        end else begin
            irq_q[`IRQ_DI] <= di_set | (irq_q[`IRQ_DI] & ~rd_di);
            irq_q[`IRQ_DO] <= ob_ready;
            irq_q[`IRQ_END] <= end_set | (irq_q[`IRQ_END] & ~(wr_start && idx == `REG_INT1));  // RULE17
            irq_q[`IRQ_NOL] <= ob_valid & ~ndac_i;                      // RULE19
            irq_q[`IRQ_PPOLL] <= is_pp;
            irq_q[12:5] <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux, bus drive, DMA, interrupt and transceiver pins
    reg [7:0] rd_val;
    always @* begin
        case (idx)                                                      // RULE2 RULE4
            `REG_DATA:  rd_val = data_in_q;
            `REG_INT1:  rd_val = irq_q[7:0];
            `REG_INT2:  rd_val = {3'h0, irq_q[12:8]};
            `REG_SPOLL: rd_val = page_q ? `VERSION_CODE : spoll_q;
            `REG_ADDR:  rd_val = addr_mode_q;
            `REG_AUX:   rd_val = page_q ? {sh_q, 6'h00} : aux_q;
            `REG_ADR01: rd_val = addr_q;
            default:    rd_val = page_q ? {dav_i, nrfd_i, ndac_i, atn_i, eoi_i, 3'h0} : eos_q;
        endcase
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            host_bus_o             <= `RST_BYTE;
            host_bus_oe_o          <= 1'b0;
            transfer_request_out_o <= 1'b0;
            int_o                  <= 1'b0;
            xcvr_dir_primary_o     <= 1'b0;
            xcvr_ctrl_second_o     <= 1'b0;
            xcvr_ctrl_third_o      <= 1'b0;
        end else begin
            host_bus_o    <= rd_val;                                    // RULE9
            host_bus_oe_o <= rd_act;                                    // RULE23
            // Ask for a byte when room or data waits; drop as soon as granted
            transfer_request_out_o <= ~grant & (ob_ready | irq_q[`IRQ_DI]);     // RULE5
            int_o <= ~(|(irq_q & mask_q)) ^ pol_hi_q;                   // RULE7 RULE8
            xcvr_dir_primary_o <= (sh_q != SH_IDLE) | ob_valid;         // RULE12
            xcvr_ctrl_second_o <= addr_mode_q[`AM_XMODE_LO];            // RULE11
            xcvr_ctrl_third_o  <= addr_mode_q[`AM_XMODE_HI];            // RULE11
        end
    end

endmodule

/* gpib_host_map.vh */
// Register offsets, field positions, reset values and timing constants for the GPIB host port
`ifndef GPIB_HOST_MAP_VH
`define GPIB_HOST_MAP_VH

// Register indices on the three select lines
`define REG_DATA        3'h0
`define REG_INT1        3'h1
`define REG_INT2        3'h2
`define REG_SPOLL       3'h3
`define REG_ADDR        3'h4
`define REG_AUX         3'h5
`define REG_ADR01       3'h6
`define REG_EOS         3'h7

// Address mode field positions
`define AM_XMODE_LO     0
`define AM_XMODE_HI     1

// Auxiliary mode command codes
`define AUX_PAGE_IN     8'h50
`define AUX_CLK_BASE    8'h20
`define AUX_POL_HI      8'h60
`define AUX_POL_LO      8'h61
`define AUX_SETTLE_BASE 8'h70

// Interrupt sources
`define NUM_IRQ         13
`define IRQ_DI          0
`define IRQ_DO          1
`define IRQ_END         2
`define IRQ_NOL         3
`define IRQ_PPOLL       4

// Reset values
`define RST_BYTE        8'h00
`define RST_CLK_MHZ     5'h08
`define CLK_MHZ_MAX     5'h14
// Version code read through the paged window; the value is arbitrary
`define VERSION_CODE    8'h01
`define RST_MASK        13'h0000

// Settle times in nanoseconds, the four choices
`define SETTLE_NS_0     350
`define SETTLE_NS_1     500
`define SETTLE_NS_2     1100
`define SETTLE_NS_3     2000
`define CLK_PERIOD_NS   40
`define NL_BYTE         8'h0A

`endif

/* gpib_host_port_properties.sv */
// Concurrent checks on the GPIB host port pins
`timescale 1ns/1ps
`include "gpib_host_map.vh"
module gpib_host_port_properties (
    input wire       clk_i,
    input wire       reset_i,
    input wire       cs_n_i,
    input wire       rd_n_i,
    input wire       wr_n_i,
    input wire [2:0] reg_index_i,
    input wire [7:0] host_bus_i,
    input wire       host_bus_oe_o,
    input wire       transfer_grant_in_n_i,
    input wire       transfer_request_out_o,
    input wire       int_o,
    input wire       dav_i,
    input wire       dav_o,
    input wire       nrfd_i,
    input wire       nrfd_o,
    input wire       ndac_i,
    input wire       atn_i,
    input wire       xcvr_dir_primary_o,
    input wire       xcvr_ctrl_second_o,
    input wire       xcvr_ctrl_third_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    // Steps of the source handshake and of a mode register write
    sequence accepted;
        dav_o && !ndac_i;
    endsequence
    sequence mode_write;
        !cs_n_i && !wr_n_i && transfer_grant_in_n_i && reg_index_i == `REG_ADDR;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    // Reset is checked without a disable, the rest pause during it
    a_reset_idle: assert property (reset_i |=>
        !host_bus_oe_o && !transfer_request_out_o && !dav_o && !int_o) else $error("outputs busy after reset");
    a_oe_read: assert property (disable iff (reset_i) host_bus_oe_o |->
        $past(!rd_n_i && (!cs_n_i || !transfer_grant_in_n_i))) else $error("bus driven outside a read");
    a_req_grant: assert property (disable iff (reset_i)
        !transfer_grant_in_n_i |=> !transfer_request_out_o) else $error("request held under grant");
    a_dir_send: assert property (disable iff (reset_i) dav_o |-> xcvr_dir_primary_o)
        else $error("valid while direction is receive");
    a_dav_start: assert property (disable iff (reset_i) $rose(dav_o) |->
        $past(!nrfd_i && ndac_i && !atn_i)) else $error("valid raised without ready listener");
    a_dav_drop: assert property (disable iff (reset_i) accepted |-> ##[1:2] !dav_o)
        else $error("valid held after acceptance");
    a_hold_unread: assert property (disable iff (reset_i)
        $rose(dav_i) && !nrfd_o |-> ##[1:3] nrfd_o) else $error("not busy with unread byte");
    a_mode_bits: assert property (disable iff (reset_i) mode_write |-> ##2
        {xcvr_ctrl_third_o, xcvr_ctrl_second_o} == $past(host_bus_i[1:0], 2)) else $error("mode pins wrong");
endmodule
bind gpib_host_port gpib_host_port_properties u_gpib_host_port_properties (
    .clk_i, .reset_i, .cs_n_i, .rd_n_i, .wr_n_i, .reg_index_i, .host_bus_i, .host_bus_oe_o,
    .transfer_grant_in_n_i, .transfer_request_out_o, .int_o, .dav_i, .dav_o, .nrfd_i, .nrfd_o,
    .ndac_i, .atn_i, .xcvr_dir_primary_o, .xcvr_ctrl_second_o, .xcvr_ctrl_third_o
);

/* gpib_listener_model.sv */
// Behavioural bus listener that accepts bytes from the port's source
`timescale 1ns/1ps
module gpib_listener_model (
    input  wire       clk_i,
    input  wire       present_i,
    input  wire       hold_i,
    input  wire       dav_i,
    input  wire [7:0] dio_i,
    output reg        nrfd_o,
    output reg        ndac_o,
    output reg  [7:0] last_o,
    output reg  [7:0] count_o
);
    initial begin
        nrfd_o = 0;
        ndac_o = 0;
        last_o = 8'h00;
        count_o = 8'h00;
    end
    // Absent means nobody holds the not-accepted line; hold stalls readiness
    always @(posedge clk_i) begin
        if (!present_i) begin
            nrfd_o <= 0;
            ndac_o <= 0;
        end else if (dav_i && ndac_o) begin
            ndac_o <= 0;
            nrfd_o <= 1;
            last_o <= dio_i;
            count_o <= count_o + 8'h01;
        end else if (!dav_i) begin
            ndac_o <= 1;
            nrfd_o <= hold_i;
        end
    end
endmodule

/* gpib_host_port_test.sv */
// Self-checking testbench for the GPIB host port
`timescale 1ns/1ps
`include "gpib_host_map.vh"
module gpib_host_port_test;
    reg        clk_i = 0, reset_i = 1, cs_n_i = 1, rd_n_i = 1, wr_n_i = 1, transfer_grant_in_n_i = 1;
    reg        dav_i = 0, atn_i = 0, eoi_i = 0, here = 0, hold = 0;
    reg  [2:0] reg_index_i = 3'h0;
    reg  [7:0] host_bus_i = 8'h00, dio_i = 8'h00, q, i, k;
    wire [7:0] host_bus_o, dio_o, last, taken;
    wire       host_bus_oe_o, transfer_request_out_o, int_o, dav_o, nrfd_o, ndac_o, nrfd_i, ndac_i;
    wire       xcvr_dir_primary_o, xcvr_ctrl_second_o, xcvr_ctrl_third_o;
    int        fail_count = 0, compares = 0, n, p;
    gpib_host_port u_gpib_host_port (.clk_i, .reset_i, .cs_n_i, .rd_n_i, .wr_n_i, .reg_index_i,
        .host_bus_i, .host_bus_o, .host_bus_oe_o, .transfer_grant_in_n_i, .transfer_request_out_o,
        .int_o, .dio_i, .dio_o, .dav_i, .dav_o, .nrfd_i, .nrfd_o, .ndac_i, .ndac_o, .atn_i, .eoi_i,
        .xcvr_dir_primary_o, .xcvr_ctrl_second_o, .xcvr_ctrl_third_o);
    gpib_listener_model u_gpib_listener_model (.clk_i, .present_i(here), .hold_i(hold), .dav_i(dav_o),
        .dio_i(dio_o), .nrfd_o(nrfd_i), .ndac_o(ndac_i), .last_o(last), .count_o(taken));
    always #20 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////////
    task chk(input [7:0] s, input [7:0] e, input string nm);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task complete_run;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // One host access; the answer is read two edges into the strobe, which is held three edges
    task acc(input w, input dma, input [2:0] idx, input [7:0] wd);
        @(posedge clk_i);
        reg_index_i <= idx;
        host_bus_i <= wd;
        cs_n_i <= dma;
        transfer_grant_in_n_i <= !dma;
        rd_n_i <= w;
        wr_n_i <= !w;
        repeat (2) @(posedge clk_i);
        #1 q = host_bus_o;
        @(posedge clk_i);
        {cs_n_i, transfer_grant_in_n_i, rd_n_i, wr_n_i} <= 4'hF;
        repeat (2) @(posedge clk_i);
    endtask
    task wdav;
        n = 0;
        while (dav_o !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 300) begin
            chk(dav_o, 1, "dav_o wait");
            complete_run;
        end
    endtask
    // A receive pulse from a bus talker
    task talk(input [7:0] b);
        dio_i <= b;
        dav_i <= 1;
        repeat (4) @(posedge clk_i);
        chk(ndac_o, 0, "ndac_o accept");
        dav_i <= 0;
        repeat (3) @(posedge clk_i);
    endtask
    initial begin
        repeat (60000) @(posedge clk_i);
        chk(0, 1, "run time");
        complete_run;
    end
    initial begin
        repeat (20) @(posedge clk_i);
        reset_i <= 0;
        here <= 1;
        @(posedge clk_i);
        chk(int_o, 0, "int_o idle");
        p = -1;
        // Longer settle choices must take longer to raise valid
        for (i = 8'h00; i < 8'h04; i++) begin
            acc(1, 0, `REG_AUX, `AUX_SETTLE_BASE + i);
            acc(1, 0, `REG_DATA, 8'hA0 + i);
            wdav;
            chk(dio_o, 8'hA0 + i, "dio_o");
            chk(n > p, 1, "settle order");
            p = n;
        end
        chk(transfer_request_out_o, 1, "request");
        acc(1, 1, 3'h5, 8'h3C);
        wdav;
        chk(dio_o, 8'h3C, "dma byte");
        $display("test transmit done");
        // No listener: three writes, two fit, the listener then stalls a while
        here <= 0;
        acc(1, 0, `REG_DATA, 8'h11);
        acc(1, 0, `REG_DATA, 8'h22);
        acc(1, 0, `REG_DATA, 8'h33);
        repeat (100) @(posedge clk_i);
        chk(dav_o, 0, "dav_o alone");
        k = taken;
        here <= 1;
        hold <= 1;
        repeat (60) @(posedge clk_i);
        hold <= 0;
        repeat (300) @(posedge clk_i);
        chk(taken - k, 8'h02, "bytes taken");
        chk(last, 8'h22, "last byte");
        // Attention arrives while the byte is settling behind a stalled listener
        hold <= 1;
        acc(1, 0, `REG_DATA, 8'h77);
        repeat (100) @(posedge clk_i);
        atn_i <= 1;
        repeat (20) @(posedge clk_i);
        chk(dav_o, 0, "dav_o attention");
        atn_i <= 0;
        hold <= 0;
        wdav;
        chk(dio_o, 8'h77, "kept byte");
        $display("test buffer done");
        // Receive path, interrupt and status
        acc(1, 0, `REG_INT1, 8'h01);
        talk(8'h5A);
        chk(int_o, 1, "int_o");
        acc(0, 0, `REG_INT1, 8'h00);
        acc(0, 0, `REG_INT1, 8'h00);
        chk(q[0], 1, "status kept");
        chk(q[2], 0, "end clear");
        acc(1, 0, `REG_AUX, `AUX_POL_LO);
        chk(int_o, 0, "int_o low");
        acc(1, 0, `REG_AUX, `AUX_POL_HI);
        acc(0, 0, `REG_DATA, 8'h00);
        chk(q, 8'h5A, "data in");
        talk(8'hC3);
        chk(transfer_request_out_o, 1, "request in");
        acc(0, 1, 3'h2, 8'h00);
        chk(q, 8'hC3, "dma read");
        talk(`NL_BYTE);
        acc(0, 0, `REG_INT1, 8'h00);
        chk(q[2], 1, "end seen");
        for (i = 8'h00; i < 8'h04; i++) begin
            acc(1, 0, `REG_ADDR, i);
            chk({xcvr_ctrl_third_o, xcvr_ctrl_second_o}, i, "mode pins");
        end
        acc(1, 0, `REG_AUX, `AUX_PAGE_IN);
        acc(0, 0, 3'h3, 8'h00);
        chk(q, 8'h01, "paged");
        acc(0, 0, 3'h3, 8'h00);
        chk(q, 8'h00, "paged out");
        // Low polarity with the data-in interrupt pending drives the pin low until reset
        acc(1, 0, `REG_AUX, `AUX_POL_LO);
        $display("test registers done");
        reset_i <= 1;
        repeat (2) @(posedge clk_i);
        reset_i <= 0;
        repeat (2) @(posedge clk_i);
        chk(int_o, 0, "int_o after reset");
        chk({xcvr_ctrl_third_o, xcvr_ctrl_second_o}, 0, "mode after reset");
        complete_run;
    end
endmodule
